// ### logic/dsol_pkg.sv
// constants and types of the dual channel safety output logic
// assumes a single 125 MHz clock and synchronous pin inputs
package dsol_pkg;
   // clock and timing
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned READY_NS = 1000;
   localparam int unsigned READY_CYC = (READY_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned BIT_NS = 8000;
   localparam logic [9:0] BIT_CYC = 10'(BIT_NS * CLK_MHZ / 1000);
   localparam logic [9:0] BIT_HALF = 10'(BIT_NS * CLK_MHZ / 2000);
   localparam int unsigned FLASH_SLOW_MS = 500;
   localparam int unsigned FLASH_FAST_MS = 125;
   localparam int unsigned FLASH_SLOW_CYC = FLASH_SLOW_MS * CLK_MHZ * 1000;
   localparam int unsigned FLASH_FAST_CYC = FLASH_FAST_MS * CLK_MHZ * 1000;
   // register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_IRQ = 8'h08;
   localparam logic [7:0] A_MASK = 8'h0c;
   localparam logic [7:0] A_NAME = 8'h10;
   // control fields and reset values
   localparam int unsigned CTRL_OPT_BIT = 0;
   localparam int unsigned CTRL_ADR_LSB = 4;
   localparam logic [7:0] CTRL_RST = 8'h01;
   localparam logic [15:0] NAME_RST = 16'h0000;
   localparam logic [3:0] TEACH_MAX = 4'h8;
   // arbitrary serial number value
   localparam logic [11:0] SERIAL_NO = 12'h5a3;
   // event bits of status and mask
   localparam int unsigned NEV = 4;
   localparam int unsigned EV_UNEQ = 0;
   localparam int unsigned EV_PERR = 1;
   localparam int unsigned EV_REL = 2;
   localparam int unsigned EV_CMD = 3;
   // diagnostic frame
   localparam int unsigned FRAME_W = 24;
   localparam logic [4:0] TX_BITS = 5'h19;
   localparam logic [3:0] RX_LAST = 4'h9;
   localparam logic [1:0] CMD_STATUS = 2'h0;
   localparam logic [1:0] CMD_CONFIG = 2'h1;
   localparam logic [1:0] CMD_NAME = 2'h2;
   typedef enum logic [1:0] {P_NORMAL, P_UNEQ, P_LOCK} dsol_pst_t;
endpackage : dsol_pkg

// ### logic/dsol_diag_if.sv
// carrier between the output logic and the diagnostic transmitter
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface dsol_diag_if;
   import dsol_pkg::*;
   logic [FRAME_W-1:0] frame;
   logic start;
   logic busy;
   logic line;
   modport ctl (output frame, output start, input busy, input line);
   modport tx (input frame, input start, output busy, output line);
endinterface : dsol_diag_if

// ### logic/dsol_plaus.sv
// plausibility monitor of the two synchronised safety inputs
// assumes the inputs are already synchronised to clk
`timescale 1ns/1ps
module dsol_plaus
   import dsol_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in1,
   input wire logic in2,
   output logic uneq,
   output logic lock,
   output logic uneq_ev,
   output logic perr_ev,
   output logic rel_ev
);
   typedef struct packed {
      dsol_pst_t st;
      logic p1, p2, ue, pe, re;
   } dsol_pl_st_t;
   dsol_pl_st_t q, d;

   always_comb
   begin
      d = q;
      d.p1 = in1;
      d.p2 = in2;
      d.ue = 1'b0;
      d.pe = 1'b0;
      d.re = 1'b0;
      case (q.st)
         // one input falls while the other stays high
         P_NORMAL:
         begin
            if ((q.p1 && !in1 && in2) || (q.p2 && !in2 && in1))
            begin
               d.st = P_UNEQ;
               d.ue = 1'b1;
            end
         end
         // fallen input returns with the other still high
         P_UNEQ:
         begin
            if (!in1 && !in2)
               d.st = P_NORMAL;
            else if (in1 && in2)
            begin
               d.st = P_LOCK;
               d.pe = 1'b1;
            end
         end
         // lock held until both inputs low together
         P_LOCK:
         begin
            if (!in1 && !in2)
            begin
               d.st = P_NORMAL;
               d.re = 1'b1;
            end
         end
         default: d.st = P_NORMAL;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= d;
   end

   assign uneq = (q.st == P_UNEQ);
   assign lock = (q.st == P_LOCK);
   assign uneq_ev = q.ue;
   assign perr_ev = q.pe;
   assign rel_ev = q.re;

   a_unequal_flag: assert property (@(posedge clk) disable iff (!rst_n)
      (q.st == P_NORMAL && q.p1 && !in1 && in2) |=> uneq && uneq_ev)
      else $error("unequal state not flagged");
   a_lock_latch: assert property (@(posedge clk) disable iff (!rst_n)
      (uneq && in1 && in2) |=> lock ##1 (lock || $past(!in1 && !in2)))
      else $error("lock not latched after plausibility error");
   c_lock_release: cover property (@(posedge clk) disable iff (!rst_n) lock ##[1:50] rel_ev);
endmodule : dsol_plaus

// ### logic/dsol_diag_tx.sv
// serial frame transmitter of the diagnostic link
// assumes start is a pulse raised only while busy is low
`timescale 1ns/1ps
module dsol_diag_tx
   import dsol_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   dsol_diag_if.tx bus
);
   typedef struct packed {
      logic busy;
      logic line;
      logic [9:0] cnt;
      logic [4:0] idx;
      logic [FRAME_W+1:0] sh;
   } dsol_tx_st_t;
   dsol_tx_st_t q, d;

   always_comb
   begin
      d = q;
      if (!q.busy)
      begin
         d.line = 1'b1;
         if (bus.start)
         begin
            // stop bit, frame, start bit; frame shifted out lsb first
            d.sh = {1'b1, bus.frame, 1'b0};
            d.busy = 1'b1;
            d.cnt = '0;
            d.idx = '0;
            d.line = 1'b0;
         end
      end
      else if (q.cnt == BIT_CYC - 10'h001)
      begin
         d.cnt = '0;
         if (q.idx == TX_BITS)
         begin
            d.busy = 1'b0;
            d.line = 1'b1;
         end
         else
         begin
            d.idx = q.idx + 5'h01;
            d.sh = {1'b1, q.sh[FRAME_W+1:1]};
            d.line = q.sh[1];
         end
      end
      else
         d.cnt = q.cnt + 10'h001;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         q <= '{busy: 1'b0, line: 1'b1, cnt: '0, idx: '0, sh: '1};
      else
         q <= d;
   end

   assign bus.busy = q.busy;
   assign bus.line = q.line;

   a_tx_idle_high: assert property (@(posedge clk) disable iff (!rst_n)
      (!q.busy && !bus.start) |=> bus.line)
      else $error("diagnostic line not idle high");
endmodule : dsol_diag_tx

// ### logic/dsol_top.sv
// dual channel safety output logic with diagnostic link and ahb-lite registers
// assumes synchronous pins, a qualified presence signal, one ahb-lite master
`timescale 1ns/1ps
module dsol_top
   import dsol_pkg::*;
#(
   parameter int unsigned SLOW_HALF_CYC = FLASH_SLOW_CYC,
   parameter int unsigned FAST_HALF_CYC = FLASH_FAST_CYC
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic first_channel_input,
   input wire logic second_channel_input,
   input wire logic actuator_present,
   input wire logic teach_done,
   input wire logic diagnostic_bus_input,
   output logic safety_out1,
   output logic safety_out2,
   output logic actuator_signal_output,
   output logic device_indicator_green,
   output logic device_indicator_red,
   output logic input_indicator,
   output logic irq
);
   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [7:0] rdy_cnt;
      logic ready;
      logic attached;
      logic [7:0] ctrl;
      logic [NEV-1:0] ev;
      logic [NEV-1:0] mask;
      logic [15:0] name;
      logic [3:0] teach_left;
      logic wr_pend;
      logic [7:0] waddr;
      logic [31:0] rdata;
      logic out1;
      logic out2;
      logic sig;
      logic irq_o;
      logic dev_g;
      logic dev_r;
      logic in_y;
      logic [31:0] slow_cnt;
      logic [31:0] fast_cnt;
      logic slow_ph;
      logic fast_ph;
      logic rx_busy;
      logic [9:0] rx_cnt;
      logic [3:0] rx_bit;
      logic [7:0] rx_sh;
      logic [FRAME_W-1:0] frame;
      logic start;
   } dsol_top_st_t;

   dsol_top_st_t q, d;
   dsol_diag_if diag ();
   logic uneq;
   logic lock;
   logic uneq_ev;
   logic perr_ev;
   logic rel_ev;
   logic in1;
   logic in2;
   logic att;
   logic cmd_ev;
   logic [NEV-1:0] clr;
   logic [15:0] payload;

   assign in1 = q.s1[1];
   assign in2 = q.s2[1];
   assign att = q.attached && q.ctrl[CTRL_OPT_BIT];

   // read value of one register; unmapped offsets read zero
   function automatic logic [31:0] reg_read(input logic [7:0] a, input dsol_top_st_t s,
                                            input logic lk, input logic ue, input logic at);
      logic [31:0] r;
      r = '0;
      case (a)
         A_CTRL: r = {24'h000000, s.ctrl};
         A_STAT: r = {20'h00000, s.teach_left, at, lk, ue, s.out2, s.out1,
                      s.s2[1], s.s1[1], s.ready};
         A_IRQ: r = {28'h0000000, s.ev};
         A_MASK: r = {28'h0000000, s.mask};
         A_NAME: r = {16'h0000, s.name};
         default: r = '0;
      endcase
      return r;
   endfunction : reg_read

   dsol_plaus u_plaus (
      .clk(hclk),
      .rst_n(hresetn),
      .in1(in1),
      .in2(in2),
      .uneq(uneq),
      .lock(lock),
      .uneq_ev(uneq_ev),
      .perr_ev(perr_ev),
      .rel_ev(rel_ev)
   );

   dsol_diag_tx u_tx (
      .clk(hclk),
      .rst_n(hresetn),
      .bus(diag.tx)
   );

   assign diag.frame = q.frame;
   assign diag.start = q.start;

   always_comb
   begin
      d = q;
      clr = '0;
      cmd_ev = 1'b0;
      payload = '0;
      // two flop synchronisers on the safety inputs
      d.s1 = {q.s1[0], first_channel_input};
      d.s2 = {q.s2[0], second_channel_input};

      // power-up settle before the device is ready
      if (!q.ready)
      begin
         if (q.rdy_cnt == 8'(READY_CYC - 1))
         begin
            d.ready = 1'b1;
            // module presence sensed anew at each power-up
            d.attached = diagnostic_bus_input;
         end
         else
            d.rdy_cnt = q.rdy_cnt + 8'h01;
      end

      // bus slave: zero wait states, address phase captured
      if (hsel && hready && htrans[1])
      begin
         d.wr_pend = hwrite;
         d.waddr = haddr[7:0];
         if (!hwrite)
            d.rdata = reg_read(haddr[7:0], q, lock, uneq, att);
      end
      else
         d.wr_pend = 1'b0;
      if (q.wr_pend)
      begin
         case (q.waddr)
            A_CTRL: d.ctrl = hwdata[7:0];
            A_IRQ: clr = hwdata[NEV-1:0];
            A_MASK: d.mask = hwdata[NEV-1:0];
            A_NAME: d.name = hwdata[15:0];
            default: d.ctrl = q.ctrl;
         endcase
      end

      // teach count starts at eight and only counts down
      if (teach_done && q.teach_left != 4'h0)
         d.teach_left = q.teach_left - 4'h1;

      // receiver runs only with a module attached
      d.start = 1'b0;
      if (!att)
         d.rx_busy = 1'b0;
      else if (!q.rx_busy)
      begin
         if (!diagnostic_bus_input)
         begin
            d.rx_busy = 1'b1;
            d.rx_cnt = BIT_HALF;
            d.rx_bit = '0;
         end
      end
      else if (q.rx_cnt == BIT_CYC - 10'h001)
      begin
         d.rx_cnt = '0;
         d.rx_bit = q.rx_bit + 4'h1;
         if (q.rx_bit == 4'h0 && diagnostic_bus_input)
            d.rx_busy = 1'b0;
         else if (q.rx_bit != 4'h0 && q.rx_bit != RX_LAST)
            d.rx_sh = {diagnostic_bus_input, q.rx_sh[7:1]};
         else if (q.rx_bit == RX_LAST)
         begin
            d.rx_busy = 1'b0;
            // four address bits select one of sixteen sensors
            if (q.rx_sh[7:4] == q.ctrl[CTRL_ADR_LSB +: 4] && !diag.busy)
            begin
               cmd_ev = 1'b1;
               case (q.rx_sh[1:0])
                  // switched state and open circuit hint
                  CMD_STATUS: payload = {q.out1 | q.out2, actuator_present, in1, in2,
                                         q.out1, q.out2, lock, uneq,
                                         q.ready && actuator_present && !in1 && !in2,
                                         7'h00};
                  CMD_CONFIG: payload = {q.teach_left, SERIAL_NO};
                  CMD_NAME: payload = q.name;
                  default: payload = 16'h0000;
               endcase
               d.frame = {q.rx_sh[7:4], 2'b00, q.rx_sh[1:0], payload};
               d.start = 1'b1;
            end
         end
      end
      else
         d.rx_cnt = q.rx_cnt + 10'h001;

      // sticky events: a new event wins over a clear
      d.ev = (q.ev & ~clr) | {cmd_ev, rel_ev, perr_ev, uneq_ev};
      d.irq_o = |(d.ev & d.mask);

      // flash rate dividers
      if (q.slow_cnt == 32'(SLOW_HALF_CYC - 1))
      begin
         d.slow_cnt = '0;
         d.slow_ph = !q.slow_ph;
      end
      else
         d.slow_cnt = q.slow_cnt + 32'h1;
      if (q.fast_cnt == 32'(FAST_HALF_CYC - 1))
      begin
         d.fast_cnt = '0;
         d.fast_ph = !q.fast_ph;
      end
      else
         d.fast_cnt = q.fast_cnt + 32'h1;

      // unequal: input fast yellow, device red flashing
      // lock: input slow yellow, device red flashing
      d.dev_g = q.ready && !uneq && !lock;
      d.dev_r = (uneq || lock) && q.slow_ph;
      if (uneq)
         d.in_y = q.fast_ph;
      else if (lock)
         d.in_y = q.slow_ph;
      else
         d.in_y = in1 && in2;

      // outputs from ready, presence, lock and own input only
      // each channel copies its own input
      // no actuator forces both outputs low
      // lock keeps outputs low until release
      d.out1 = q.ready && actuator_present && !lock && in1;
      d.out2 = q.ready && actuator_present && !lock && in2;
      // plain presence level without diagnostic module
      // diagnostic data replace the presence level
      d.sig = att ? diag.line : (q.ready && actuator_present);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q <= '0;
         q.ctrl <= CTRL_RST;
         q.name <= NAME_RST;
         q.teach_left <= TEACH_MAX;
      end
      else
         q <= d;
   end

   assign hrdata = q.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign safety_out1 = q.out1;
   assign safety_out2 = q.out2;
   assign actuator_signal_output = q.sig;
   assign device_indicator_green = q.dev_g;
   assign device_indicator_red = q.dev_r;
   assign input_indicator = q.in_y;
   assign irq = q.irq_o;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_outs_absent: assert property (!actuator_present |=> !safety_out1 && !safety_out2)
      else $error("safety output high without actuator");
   a_sig_absent: assert property ((!actuator_present && !att) |=> !actuator_signal_output)
      else $error("signal output high without actuator");
   a_sig_present: assert property ((actuator_present && q.ready && !att)
      |=> actuator_signal_output)
      else $error("signal output low with actuator present");
   a_chan_follow: assert property ((q.ready && actuator_present && !lock)
      |=> (safety_out1 == $past(in1)) && (safety_out2 == $past(in2)))
      else $error("safety output does not copy its input");
   a_not_ready: assert property (!q.ready |=> !safety_out1 && !safety_out2)
      else $error("safety output high before ready");
   a_lock_holds: assert property (lock |=> !safety_out1 && !safety_out2)
      else $error("safety output high under lock");
   a_teach_count: assert property ((teach_done && q.teach_left != 4'h0)
      |=> q.teach_left == $past(q.teach_left) - 4'h1)
      else $error("teach count not decremented");
   a_teach_max: assert property (q.teach_left <= TEACH_MAX)
      else $error("teach count above eight");
   a_diag_ignored: assert property (!att |=> !q.rx_busy && !q.start)
      else $error("diagnostic input used without module");
   a_sig_data: assert property (att |=> actuator_signal_output == $past(diag.line))
      else $error("signal output does not carry diagnostic data");
   a_irq_level: assert property ((!q.wr_pend &&
      ({cmd_ev, rel_ev, perr_ev, uneq_ev} & q.mask) != '0) |=> irq)
      else $error("interrupt low after unmasked event");
   a_attach_sense: assert property ((!q.ready && q.rdy_cnt == 8'(READY_CYC - 1))
      |=> q.attached == $past(diagnostic_bus_input))
      else $error("module presence not sensed at ready");
   a_sync_chain: assert property (q.ready |-> in1 == $past(first_channel_input, 2))
      else $error("safety input not synchronised in two stages");

   c_lock_seen: cover property (perr_ev ##[1:100] rel_ev);
   c_frame_sent: cover property (q.start ##1 diag.busy);
   c_teach_out: cover property (q.teach_left == 4'h0);
   c_uneq_seen: cover property (uneq_ev ##[1:20] perr_ev);
endmodule : dsol_top

// ### dv/dsol_fbus_model.sv
// fieldbus module model on the diagnostic serial link of the block
// assumes the block's signal output idles high and one bit lasts bit_cyc clocks
`timescale 1ns/1ps
module dsol_fbus_model
   import dsol_pkg::*;
(
   input wire logic clk,
   input wire logic sig_in,
   output logic line_out
);
   int unsigned bit_cyc = 1000;
   initial line_out = 1'b0;
   // idle level at ready decides attachment after each power-up
   task automatic set_idle(input logic v);
      line_out <= v;
   endtask : set_idle
   // four address bits reach each of sixteen chain members
   task automatic send_cmd(input logic [3:0] adr, input logic [1:0] cmd);
      logic [9:0] sh;
      sh = {1'b1, adr, 2'b00, cmd, 1'b0};
      for (int i = 0; i < 9; i++)
      begin
         line_out <= sh[i];
         repeat (bit_cyc) @(posedge clk);
      end
      line_out <= 1'b1;
   endtask : send_cmd
   // reply frame taken mid-bit, lsb first
   task automatic recv_frame(output logic [23:0] f, output bit ok);
      int n;
      n = 0;
      f = 24'h0;
      ok = 0;
      while (sig_in !== 1'b0 && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 3000)
         return;
      repeat (bit_cyc / 2) @(posedge clk);
      for (int i = 0; i < 24; i++)
      begin
         repeat (bit_cyc) @(posedge clk);
         f[i] = sig_in;
      end
      repeat (bit_cyc) @(posedge clk);
      ok = (sig_in === 1'b1);
   endtask : recv_frame
endmodule : dsol_fbus_model

// ### dv/dual_channel_safety_output_logic_tb_top.sv
// self-checking bench of the safety output logic and its register bus
// assumes a single ahb-lite master and one slave, shortened flash periods
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin miscompares++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module dual_channel_safety_output_logic_tb_top
   import dsol_pkg::*;
;
   typedef struct packed {logic [2:0] pin; logic [2:0] pout;} dsol_row_t;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic in1 = 1, in2 = 1, present = 1, teach_done = 0, diag_line;
   logic out1, out2, sig, green, red, in_ind, irq, hresp;
   logic [23:0] frm;
   bit ok, hi1, lo1, hi2, lo2;
   int miscompares = 0, check_count = 0, cyc = 0;
   dsol_row_t rows [9] = '{{3'b111, 3'b111}, {3'b011, 3'b000}, {3'b000, 3'b000},
      {3'b100, 3'b001}, {3'b110, 3'b101}, {3'b100, 3'b001}, {3'b101, 3'b011},
      {3'b100, 3'b001}, {3'b111, 3'b111}};
   dsol_top #(.SLOW_HALF_CYC(8), .FAST_HALF_CYC(4)) dut_u (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
      .first_channel_input(in1), .second_channel_input(in2), .actuator_present(present),
      .teach_done(teach_done), .diagnostic_bus_input(diag_line), .safety_out1(out1),
      .safety_out2(out2), .actuator_signal_output(sig), .device_indicator_green(green),
      .device_indicator_red(red), .input_indicator(in_ind), .irq(irq));
   dsol_fbus_model fbus_u (.clk(hclk), .sig_in(sig), .line_out(diag_line));
   initial forever #4 hclk = ~hclk;
   task automatic test_done();
      if (miscompares == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 110000)
      begin
         miscompares++;
         test_done();
      end
   end
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
      #1;
   endtask : ahb
   task automatic set_in(input logic [2:0] v);
      @(posedge hclk);
      {present, in1, in2} <= v;
      repeat (6) @(posedge hclk);
      #1;
   endtask : set_in
   task automatic flashes();
      {hi1, lo1, hi2, lo2} = 4'b0000;
      repeat (24)
      begin
         @(posedge hclk);
         #1;
         hi1 |= in_ind === 1'b1;
         lo1 |= in_ind === 1'b0;
         hi2 |= red === 1'b1;
         lo2 |= red === 1'b0;
      end
   endtask : flashes
   task automatic pulse_reset();
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (100) @(posedge hclk);
      #1;
      `CHK("out1 before ready", 1'b0, out1)
      repeat (READY_CYC) @(posedge hclk);
      #1;
   endtask : pulse_reset
   initial
   begin
      fbus_u.set_idle(1'b0);
      pulse_reset();
      `CHK("green", 1'b1, green)
      ahb(1'b0, A_STAT, 0);
      `CHK("status", {20'h0, TEACH_MAX, 8'h1f}, rd)
      `CHK("okay response", 1'b0, hresp)
      ahb(1'b1, A_STAT, 32'hffffffff);
      ahb(1'b0, A_STAT, 0);
      `CHK("status ro", {20'h0, TEACH_MAX, 8'h1f}, rd)
      ahb(1'b0, A_CTRL, 0);
      `CHK("ctrl", {24'h0, CTRL_RST}, rd)
      ahb(1'b1, A_NAME, 32'h0000beef);
      ahb(1'b0, A_NAME, 0);
      `CHK("name", 32'h0000beef, rd)
      ahb(1'b0, 8'h20, 0);
      `CHK("unmapped", 32'h0, rd)
      foreach (rows[i])
      begin
         set_in(rows[i].pin);
         `CHK("outs", rows[i].pout, {out1, out2, sig})
      end
      ahb(1'b1, A_IRQ, 32'hf);
      ahb(1'b1, A_MASK, 32'hf);
      set_in(3'b101);
      `CHK("uneq outs", 2'b01, {out1, out2})
      `CHK("uneq irq", 1'b1, irq)
      flashes();
      `CHK("uneq flash", 4'hf, {hi1, lo1, hi2, lo2})
      set_in(3'b111);
      `CHK("lock outs", 2'b00, {out1, out2})
      `CHK("lock green", 1'b0, green)
      flashes();
      `CHK("lock flash", 4'hf, {hi1, lo1, hi2, lo2})
      ahb(1'b0, A_STAT, 0);
      `CHK("lock stat", 2'b10, rd[6:5])
      ahb(1'b0, A_IRQ, 0);
      `CHK("irq bits", 32'h3, rd)
      ahb(1'b1, A_IRQ, 32'hf);
      ahb(1'b1, A_MASK, 32'h0);
      set_in(3'b100);
      `CHK("masked irq", 1'b0, irq)
      ahb(1'b0, A_IRQ, 0);
      `CHK("release ev", 32'h4, rd)
      set_in(3'b111);
      `CHK("released outs", 2'b11, {out1, out2})
      ahb(1'b1, A_MASK, 32'h4);
      repeat (2) @(posedge hclk);
      #1;
      `CHK("unmasked irq", 1'b1, irq)
      ahb(1'b1, A_IRQ, 32'h4);
      repeat (2) @(posedge hclk);
      #1;
      `CHK("cleared irq", 1'b0, irq)
      for (int i = 1; i < 10; i++)
      begin
         @(posedge hclk);
         teach_done <= 1'b1;
         @(posedge hclk);
         teach_done <= 1'b0;
         ahb(1'b0, A_STAT, 0);
         if (i == 1 || i == 9)
            `CHK("teach cnt", (i == 1) ? 4'h7 : 4'h0, rd[11:8])
      end
      fbus_u.set_idle(1'b1);
      pulse_reset();
      ahb(1'b0, A_STAT, 0);
      `CHK("attached", 1'b1, rd[7])
      fbus_u.send_cmd(4'h5, CMD_STATUS);
      fbus_u.recv_frame(frm, ok);
      `CHK("foreign addr", 1'b0, ok)
      fbus_u.send_cmd(4'h0, CMD_CONFIG);
      fbus_u.recv_frame(frm, ok);
      `CHK("config", {1'b1, 4'h0, 2'b00, CMD_CONFIG, TEACH_MAX, SERIAL_NO}, {ok, frm})
      ahb(1'b1, A_NAME, 32'h00001234);
      fbus_u.send_cmd(4'h0, CMD_NAME);
      fbus_u.recv_frame(frm, ok);
      `CHK("name frame", {1'b1, 4'h0, 2'b00, CMD_NAME, 16'h1234}, {ok, frm})
      ahb(1'b1, A_CTRL, 32'h0);
      ahb(1'b0, A_STAT, 0);
      `CHK("option off", 2'b01, {rd[7], sig})
      test_done();
   end
endmodule : dual_channel_safety_output_logic_tb_top
